// *** rtl/pss_consts.svh ***
`ifndef PSS_CONSTS_SVH
`define PSS_CONSTS_SVH

// Signature store width in bits
`define PSS_SIG_BITS 64
// Configuration pattern word width and depth
`define PSS_CFG_BITS 16
`define PSS_CFG_WORDS 8
// Longest power-up clear time in ns, and its cycle count at 25 ns per cycle (rounded down)
`define PSS_CLEAR_TIME_NS 45000
`define PSS_CLK_PERIOD_NS 25
`define PSS_CLEAR_CYCLES (`PSS_CLEAR_TIME_NS / `PSS_CLK_PERIOD_NS)
// Clock-valid window in ns, for reference by the system side
`define PSS_CLOCK_VALID_WINDOW_NS 100
// Reset values
`define PSS_SIG_RESET 64'h0000_0000_0000_0000
`define PSS_SECURE_RESET 1'b0
// Readback value when access is refused
`define PSS_REFUSED_DATA 16'hffff

`endif

// *** rtl/pss_pkg.sv ***
package pss_pkg;
	// Programmer command codes
	typedef enum logic [2:0] {
		PSS_CMD_NONE,
		PSS_CMD_PROGRAM,
		PSS_CMD_READ_CFG,
		PSS_CMD_READ_SIG,
		PSS_CMD_SECURE
	} pss_cmd_t;

	// One programmer request
	typedef struct packed {
		logic     valid;
		pss_cmd_t cmd;
		logic [2:0]  addr;
		logic [15:0] cfg_data;
		logic [63:0] sig_data;
	} pss_req_t;

	// One programmer answer
	typedef struct packed {
		logic        valid;
		logic        refused;
		logic [15:0] data;
		logic [63:0] sig;
		logic [15:0] checksum;
	} pss_rsp_t;
endpackage

// *** rtl/pss_powerup.sv ***
`timescale 1ns/1ps
`include "pss_consts.svh"
// Power-up clear counter: holds clear high until the count runs out
module pss_powerup
	import pss_pkg::*;
#(
	parameter int CLEAR_CYCLES = `PSS_CLEAR_CYCLES
)(
	input  wire logic clk,     // Device clock
	input  wire logic reset,   // Power-on, async active high
	output logic      clear    // Internal register clear, high until released
);
	typedef struct packed {
		logic [15:0] count;
		logic        busy;
	} pss_pu_state_t;

	pss_pu_state_t st;
	pss_pu_state_t next_st;

	// Count down the clear time, then release
	always_comb
	begin
		next_st = st;
		if (st.busy)
		begin
			if (st.count == 16'h0001)
				next_st.busy = 1'b0;
			else
				next_st.count = st.count - 16'h0001;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			st <= {16'(CLEAR_CYCLES), 1'b1};
		else
			st <= next_st;
	end

	assign clear = st.busy | reset;
endmodule // pss_powerup

// *** rtl/pss_top.sv ***
`timescale 1ns/1ps
`include "pss_consts.svh"
// Operation
// - A 64-bit reprogrammable signature holds any user data.
// - Signature reads always succeed, regardless of the protection cell.
// - Checksum covers signature bits; its four 16-bit words are added to the pattern words.
// - After protection is set, configuration readback is refused.
// - Protection clears only through a full reprogramming.
// - Power-up reset drives the output and answer registers low within 45 us.
// - Enabled registered outputs read high after power-up, via inverting path.
// - Programming erases the old configuration automatically.
// - Undriven inputs read as one; tri-stated output pins (out_en low) read as zero on pin_out.
module pss_top
	import pss_pkg::*;
#(
	parameter int CLEAR_CYCLES = `PSS_CLEAR_CYCLES, // Power-up clear length
	parameter int OUT_BITS     = 4                  // Registered output pins
)(
	input  wire logic                clk,        // Device clock
	input  wire logic                reset,      // Power-on reset, active high
	input  pss_req_t                 req,        // Programmer request
	output pss_rsp_t                 rsp,        // Programmer answer
	input  wire logic [OUT_BITS-1:0] d_in,       // Next-state data for output registers
	input  wire logic [OUT_BITS-1:0] d_in_oe,    // Drive enable seen on d_in pins
	input  wire logic [OUT_BITS-1:0] out_en,     // Output enables
	output logic [OUT_BITS-1:0]      pin_out,    // Registered output pin levels
	output logic                     powerup_busy // Clear still active
);
	typedef struct packed {
		logic [`PSS_CFG_WORDS-1:0][`PSS_CFG_BITS-1:0] cfg;
		logic [`PSS_SIG_BITS-1:0] sig;
		logic                     secure;
		logic [OUT_BITS-1:0]      q;
		pss_rsp_t                 rsp;
	} pss_state_t;

	pss_state_t st;
	pss_state_t next_st;
	logic       clear;
	logic [OUT_BITS-1:0] din_eff;

	// Checksum over the pattern and the signature, used three times
	function automatic logic [15:0] pss_sum(
		input logic [`PSS_CFG_WORDS-1:0][`PSS_CFG_BITS-1:0] c,
		input logic [`PSS_SIG_BITS-1:0] s
	);
		logic [15:0] acc;
		acc = 16'h0000;
		for (int i = 0; i < `PSS_CFG_WORDS; i++)
			acc = acc + c[i];
		for (int j = 0; j < 4; j++)
			acc = acc + s[j*16 +: 16];
		return acc;
	endfunction

	pss_powerup #(
		.CLEAR_CYCLES(CLEAR_CYCLES)
	) u_powerup (
		.clk  (clk),
		.reset(reset),
		.clear(clear)
	);

	// Pull-ups: a pin not driven reads one
	assign din_eff = d_in | ~d_in_oe;

	// Command handling and output registers
	always_comb
	begin
		next_st = st;
		next_st.rsp = '0;
		next_st.q = din_eff;
		if (req.valid)
		begin
			case (req.cmd)
				PSS_CMD_PROGRAM:
				begin
					// Whole pattern erased before the new word lands
					next_st.cfg = '0;
					next_st.cfg[req.addr] = req.cfg_data;
					next_st.sig = req.sig_data;
					next_st.secure = `PSS_SECURE_RESET;
					next_st.rsp.valid = 1'b1;
				end
				PSS_CMD_READ_CFG:
				begin
					next_st.rsp.valid = 1'b1;
					if (st.secure)
					begin
						next_st.rsp.refused = 1'b1;
						next_st.rsp.data = `PSS_REFUSED_DATA;
					end
					else
						next_st.rsp.data = st.cfg[req.addr];
				end
				PSS_CMD_READ_SIG:
				begin
					next_st.rsp.valid = 1'b1;
					next_st.rsp.sig = st.sig;
				end
				PSS_CMD_SECURE:
				begin
					next_st.secure = 1'b1;
					next_st.rsp.valid = 1'b1;
				end
				default:
				begin
					next_st.rsp.valid = 1'b0;
				end
			endcase
			next_st.rsp.checksum = pss_sum(st.cfg, st.sig);
		end
	end

	// Clock edges ignored while the power-up clear holds the output and answer registers at zero
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			// Only output and answer registers clear; the pattern, signature
			// and protection cell are non-volatile, so a power cycle cannot
			// be used to drop the protection
			st.q   <= '0;
			st.rsp <= '0;
		end
		else if (clear)
		begin
			st.q   <= '0;
			st.rsp <= '0;
		end
		else
			st <= next_st;
	end

	// Inverting output buffer: cleared register shows high when enabled
	assign pin_out = ~st.q & out_en;
	assign rsp = st.rsp;
	assign powerup_busy = clear;

	property p_refuse;
		@(posedge clk) disable iff (reset)
		(!clear && req.valid && req.cmd == PSS_CMD_READ_CFG && st.secure)
			|=> (rsp.valid && rsp.refused);
	endproperty
	a_refuse: assert property (p_refuse) else $error("cfg read not refused");

	property p_sig_read;
		@(posedge clk) disable iff (reset)
		(!clear && req.valid && req.cmd == PSS_CMD_READ_SIG)
			|=> (rsp.valid && !rsp.refused && rsp.sig == $past(st.sig));
	endproperty
	a_sig_read: assert property (p_sig_read) else $error("sig read wrong");

	property p_secure_hold;
		@(posedge clk) disable iff (reset)
		(st.secure && !(req.valid && req.cmd == PSS_CMD_PROGRAM)) |=> st.secure;
	endproperty
	a_secure_hold: assert property (p_secure_hold) else $error("secure lost");

	property p_prog_clears;
		@(posedge clk) disable iff (reset)
		(!clear && req.valid && req.cmd == PSS_CMD_PROGRAM) |=> (!st.secure && rsp.valid);
	endproperty
	a_prog_clears: assert property (p_prog_clears) else $error("program kept cell");

	property p_sig_store;
		@(posedge clk) disable iff (reset)
		(!clear && req.valid && req.cmd == PSS_CMD_PROGRAM) |=> (st.sig == $past(req.sig_data));
	endproperty
	a_sig_store: assert property (p_sig_store) else $error("sig not stored");

	property p_clear_zero;
		@(posedge clk) disable iff (reset)
		clear |=> (st.q == '0 || !$past(clear));
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("reg moved in clear");

	property p_pin_high;
		@(posedge clk) disable iff (reset)
		clear |-> (pin_out == out_en);
	endproperty
	a_pin_high: assert property (p_pin_high) else $error("pin not high");

	property p_checksum;
		@(posedge clk) disable iff (reset)
		(!clear && req.valid && req.cmd == PSS_CMD_READ_SIG)
			|=> (rsp.checksum == pss_sum($past(st.cfg), $past(st.sig)));
	endproperty
	a_checksum: assert property (p_checksum) else $error("checksum wrong");

	property p_pullup;
		@(posedge clk) disable iff (reset)
		(!clear && d_in_oe == '0) |=> (st.q == '1);
	endproperty
	a_pullup: assert property (p_pullup) else $error("pull-up missing");

	// Programming leaves only the new word behind, so the pattern sum is that word
	property p_erase;
		@(posedge clk) disable iff (reset)
		(!clear && req.valid && req.cmd == PSS_CMD_PROGRAM)
			|=> (pss_sum(st.cfg, '0) == $past(req.cfg_data));
	endproperty
	a_erase: assert property (p_erase) else $error("old pattern not erased");

	property p_secure_set;
		@(posedge clk) disable iff (reset)
		(!clear && req.valid && req.cmd == PSS_CMD_SECURE) |=> (st.secure && rsp.valid);
	endproperty
	a_secure_set: assert property (p_secure_set) else $error("cell not set");

	property p_cfg_read;
		@(posedge clk) disable iff (reset)
		(!clear && req.valid && req.cmd == PSS_CMD_READ_CFG && !st.secure)
			|=> (rsp.valid && !rsp.refused && rsp.data == $past(st.cfg[req.addr]));
	endproperty
	a_cfg_read: assert property (p_cfg_read) else $error("open cfg read wrong");

	// No answer may leave while the power-up clear still holds the block
	property p_clear_hold;
		@(posedge clk) disable iff (reset)
		clear |=> !rsp.valid;
	endproperty
	a_clear_hold: assert property (p_clear_hold) else $error("answer during clear");
endmodule // pss_top

// *** test/pss_prog.sv ***
`timescale 1ns/1ps
// Programmer stand-in: nothing is sent while the clear runs
module pss_prog
	import pss_pkg::*;
(
	input  wire logic clk,  // Device clock
	input  pss_req_t  want, // Request the bench asks for
	input  wire logic busy, // Power-up clear active
	output pss_req_t  req   // Request seen by the device
);
	// Combinational gate, want already moves off the sampling edge
	always_comb
	begin
		req = busy ? '0 : want;
	end
endmodule // pss_prog

// *** test/pss_top_tb.sv ***
`timescale 1ns/1ps
module pss_top_tb;
	import pss_pkg::*;
	typedef struct packed {
		pss_cmd_t    cmd;
		logic [2:0]  a;
		logic [15:0] d;
		logic [63:0] s;
		logic        rf;
		logic [15:0] cs;
	} pss_row_t;
	localparam int CC = 8;
	logic       clk     = 0;
	logic       reset   = 1;
	pss_req_t   want    = '0;
	pss_req_t   req;
	pss_rsp_t   rsp;
	logic [3:0] d_in    = 4'h0;
	logic [3:0] d_in_oe = 4'hf;
	logic [3:0] out_en  = 4'ha;
	logic [3:0] pin_out;
	logic       busy;
	int         n_mismatch  = 0;
	int         comparisons = 0;
	// Write data doubles as expected read data
	pss_row_t rows[13] = '{
		'{PSS_CMD_PROGRAM, 3'h3, 16'h1234, 64'h0, 1'b0, 16'h0},
		'{PSS_CMD_READ_CFG, 3'h3, 16'h1234, 64'h0, 1'b0, 16'h1234},
		'{PSS_CMD_READ_CFG, 3'h0, 16'h0000, 64'h0, 1'b0, 16'h1234},
		'{PSS_CMD_PROGRAM, 3'h5, 16'h00ab, 64'h0001_0002_0003_0004, 1'b0, 16'h0},
		'{PSS_CMD_READ_CFG, 3'h3, 16'h0000, 64'h0, 1'b0, 16'h00b5},
		'{PSS_CMD_READ_SIG, 3'h0, 16'h0, 64'h0001_0002_0003_0004, 1'b0, 16'h00b5},
		'{PSS_CMD_SECURE, 3'h0, 16'h0, 64'h0, 1'b0, 16'h0},
		'{PSS_CMD_READ_CFG, 3'h5, 16'h0, 64'h0, 1'b1, 16'h0},
		'{PSS_CMD_READ_SIG, 3'h0, 16'h0, 64'h0001_0002_0003_0004, 1'b0, 16'h00b5},
		'{PSS_CMD_READ_CFG, 3'h3, 16'h0, 64'h0, 1'b1, 16'h0},
		'{PSS_CMD_PROGRAM, 3'h5, 16'h0077, 64'h0, 1'b0, 16'h0},
		'{PSS_CMD_READ_CFG, 3'h5, 16'h0077, 64'h0, 1'b0, 16'h0077},
		'{PSS_CMD_SECURE, 3'h0, 16'h0, 64'h0, 1'b0, 16'h0}};

	// Clock toggles from time zero
	always #12.5 clk = ~clk;

	pss_top #(.CLEAR_CYCLES(CC), .OUT_BITS(4)) DUT (.clk(clk), .reset(reset), .req(req),
		.rsp(rsp), .d_in(d_in), .d_in_oe(d_in_oe), .out_en(out_en), .pin_out(pin_out),
		.powerup_busy(busy));
	pss_prog prog (.clk(clk), .want(want), .busy(busy), .req(req));

	task chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task test_done;
		$display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// One request; the answer stands for one cycle only, so look right after the edge
	task op(input pss_row_t r);
		@(negedge clk) want = '{1'b1, r.cmd, r.a, r.d, r.s};
		@(negedge clk) want = '0;
		chk(rsp.valid, 1);
		chk(rsp.refused, r.rf);
		if (r.cmd == PSS_CMD_READ_CFG)
			chk(rsp.data, r.rf ? 16'hffff : r.d);
		if (r.cmd == PSS_CMD_READ_SIG)
			chk(rsp.sig, r.s);
		if ((r.cmd == PSS_CMD_READ_CFG || r.cmd == PSS_CMD_READ_SIG) && !r.rf)
			chk(rsp.checksum, r.cs);
	endtask

	// Hang guard
	initial
	begin
		#100us;
		n_mismatch++;
		test_done();
	end

	initial
	begin
		repeat (10) @(negedge clk);
		chk(busy, 1);
		chk(pin_out, 4'ha);
		reset = 0;
		d_in  = 4'hf;
		repeat (CC - 1) @(negedge clk);
		chk(busy, 1);
		chk(pin_out, 4'ha);
		for (int i = 0; i < 5 && busy; i++)
			@(negedge clk);
		chk(busy, 0);
		if (busy)
			test_done();
		@(negedge clk);
		chk(pin_out, 4'h0);
		// Undriven bits 1 and 3 must load as ones
		out_en  = 4'hf;
		d_in    = 4'h0;
		d_in_oe = 4'h5;
		repeat (2) @(negedge clk);
		chk(pin_out, 4'h5);
		// All pins floating load ones
		d_in_oe = 4'h0;
		repeat (2) @(negedge clk);
		chk(pin_out, 4'h0);
		d_in_oe = 4'hf;
		foreach (rows[i])
			op(rows[i]);
		// Second power-up mid-run: outputs clear, protection must survive it
		d_in  = 4'hf;
		reset = 1;
		@(negedge clk);
		chk(pin_out, 4'hf);
		chk(busy, 1);
		reset = 0;
		for (int i = 0; i < CC + 2 && busy; i++)
			@(negedge clk);
		chk(busy, 0);
		if (busy)
			test_done();
		chk(pin_out, 4'hf);
		op('{PSS_CMD_READ_CFG, 3'h5, 16'h0, 64'h0, 1'b1, 16'h0});
		chk(pin_out, 4'h0);
		test_done();
	end
endmodule // pss_top_tb
